// >>> verilog/irp_top.sv
// interrupt request pin logic: sync, edge/level detect, cascade, slave, pwd
// assumes core raises ready at instruction boundaries and sets global enable via sti
`timescale 1ns/1ns

// How it works
// - requests synchronised, edge or level recognised
// - unmasked request a vectors to its entry
// - cascade a turns pin c into ack
// - cascade b turns pin d into ack
// - slave mode: pin b is select input
// - slave mode: pin d drives request out
// - demodulator drives timers and requests c, e
// - pwd mode: request e on falling edges
// - pwd mode: timer and e pins ignored
// - demodulator level shown at gpio bit 31
// - unused dma0 pin becomes request, type 0A
// - unused dma1 pin becomes request, type 0B
// - taking an interrupt clears global enable
module irp_top
    import irp_pkg::*;
#(
    parameter logic [7:0] TYPE_A = irp_pkg::IRP_TYPE_A
) (
    input  wire logic                clk_sys_in,
    input  wire logic                rst_b_in,
    input  wire irp_pkg::irp_cfg_type cfg_in,
    input  wire logic                ext_request_a_in,
    input  wire logic                ext_request_b_in,
    input  wire logic                ext_request_c_in,
    input  wire logic                ext_request_d_in,
    input  wire logic                ext_request_e_in,
    input  wire logic                dma_chan0_request_in,
    input  wire logic                dma_chan1_request_in,
    input  wire logic                pwd_in,
    input  wire logic                timer_pin_zero_in,
    input  wire logic                timer_pin_one_in,
    input  wire logic                core_ready_in,
    input  wire logic                sti_in,
    input  wire logic                slave_irq_in,
    input  wire logic [7:0]          bus_type_in,
    output irp_pkg::irp_take_type    take_out,
    output logic                     global_enable_out,
    output logic                     cascade_ack_a_out,
    output logic                     cascade_ack_b_out,
    output logic                     pin_d_oe_b_out,
    output logic                     pin_c_oe_b_out,
    output logic                     slave_irq_out,
    output logic                     timer_input_zero_out,
    output logic                     timer_input_one_out,
    output logic                     gpio_bit_thirtyone_out,
    output logic [1:0]               dma_chan_request_out
);
    import irp_pkg::*;

    // =====================================================
    // synchronisers
    logic [9:0] raw_pins;
    logic [9:0] s;
    assign raw_pins = {timer_pin_one_in, timer_pin_zero_in, pwd_in,
                       dma_chan1_request_in, dma_chan0_request_in, ext_request_e_in,
                       ext_request_d_in, ext_request_c_in, ext_request_b_in,
                       ext_request_a_in};

    irp_sync #(.WIDTH(10)) u_sync (
        .clk_sys_in (clk_sys_in),
        .rst_b_in   (rst_b_in),
        .async_in   (raw_pins),
        .sync_out   (s)
    );

    // =====================================================
    // source selection
    logic          pwd_s;
    logic [6:0]    src_lvl;
    logic [6:0]    src_prev_q;
    logic [6:0]    pend_q;
    logic [6:0]    active;
    logic          gie_q;
    irp_state_type st_q;

    assign pwd_s = s[7];
    always_comb begin
        src_lvl = '0;
        src_lvl[IRP_SRC_A] = s[0];
        // select role takes pin b in slave mode
        src_lvl[IRP_SRC_B] = s[1] & ~cfg_in.slave_mode;
        // pin c is an ack output in cascade a
        src_lvl[IRP_SRC_C] = cfg_in.pwd_enable ? pwd_s
                           : (s[2] & ~cfg_in.cascade_a);
        src_lvl[IRP_SRC_D] = s[3] & ~cfg_in.cascade_b & ~cfg_in.slave_mode;
        // inverse drives e; pin e level ignored in pwd mode
        src_lvl[IRP_SRC_E] = cfg_in.pwd_enable ? ~pwd_s : s[4];
        src_lvl[IRP_SRC_DMA0] = s[5] & cfg_in.dma0_unused;
        src_lvl[IRP_SRC_DMA1] = s[6] & cfg_in.dma1_unused;
    end

    // =====================================================
    // recognition: edge sets sticky pending, level is live
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            src_prev_q <= IRP_RST_PEND;
        end else begin
            src_prev_q <= src_lvl;
        end
    end

    function automatic logic [2:0] irp_pick(input logic [6:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = IRP_NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    logic [6:0] rise;
    logic       do_take;
    logic       slave_take;
    logic [2:0] win;
    assign rise = src_lvl & ~src_prev_q;
    // level-mode sources follow the pin, no latch; edge-mode sources go through pend_q
    assign active = ((pend_q & ~cfg_in.level_mode) | (src_lvl & cfg_in.level_mode))
                    & ~cfg_in.mask;
    assign win = irp_pick(active);
    assign do_take = (st_q == IRP_ST_IDLE) & gie_q & core_ready_in & (|active)
                     & ~cfg_in.slave_mode;

    // new edge in the clearing cycle wins over the clear
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pend_q <= IRP_RST_PEND;
        end else begin
            // a select-vectored take retires request a too, else it fires after slave mode
            pend_q <= (pend_q & ~(do_take ? (7'h01 << win) : 7'h00)
                              & ~(slave_take ? (7'h01 << IRP_SRC_A) : 7'h00))
                      | (rise & ~cfg_in.level_mode);
        end
    end

    function automatic logic [7:0] irp_type(input logic [2:0] src);
        case (src)
            3'(IRP_SRC_DMA0): irp_type = IRP_TYPE_DMA0;
            3'(IRP_SRC_DMA1): irp_type = IRP_TYPE_DMA1;
            default:          irp_type = 8'(TYPE_A + {5'h00, src});
        endcase
    endfunction

    // =====================================================
    // acknowledge sequencer for cascade and slave vectoring
    logic        cas_sel;
    logic        slave_sel;
    logic        slave_sel_prev_q;
    assign cas_sel   = (win == 3'(IRP_SRC_A) & cfg_in.cascade_a)
                     | (win == 3'(IRP_SRC_B) & cfg_in.cascade_b);
    assign slave_sel = ~s[1] & cfg_in.slave_mode; // active-low select
    // select honoured only with request a present
    assign slave_take = (st_q == IRP_ST_IDLE) & slave_sel & ~slave_sel_prev_q
                        & gie_q & s[0];

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_q              <= IRP_ST_IDLE;
            take_out          <= '0;
            cascade_ack_a_out <= 1'b1;
            cascade_ack_b_out <= 1'b1;
            slave_sel_prev_q  <= 1'b0;
        end else begin
            take_out.take    <= 1'b0;
            slave_sel_prev_q <= slave_sel;
            case (st_q)
                IRP_ST_IDLE: begin
                    if (do_take & cas_sel) begin
                        st_q <= IRP_ST_ACK;
                        cascade_ack_a_out <= ~(win == 3'(IRP_SRC_A));
                        cascade_ack_b_out <= ~(win == 3'(IRP_SRC_B));
                        take_out.source   <= win;
                    end else if (do_take) begin
                        take_out <= '{take: 1'b1, vector_type: irp_type(win),
                                      source: win};
                    end else if (slave_take) begin
                        take_out <= '{take: 1'b1, vector_type: bus_type_in,
                                      source: 3'(IRP_SRC_A)};
                    end
                end
                IRP_ST_ACK: begin
                    // type read from bus one cycle into the ack
                    st_q <= IRP_ST_WAIT;
                    take_out.take        <= 1'b1;
                    take_out.vector_type <= bus_type_in;
                end
                IRP_ST_WAIT: begin
                    st_q <= IRP_ST_IDLE;
                    cascade_ack_a_out <= 1'b1;
                    cascade_ack_b_out <= 1'b1;
                end
                default: st_q <= IRP_ST_IDLE;
            endcase
        end
    end

    // =====================================================
    // global enable: cleared on take, set by sti
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            gie_q <= 1'b0;
        end else if (do_take | slave_take) begin
            gie_q <= 1'b0;
        end else if (sti_in) begin
            gie_q <= 1'b1;
        end
    end
    assign global_enable_out = gie_q;

    // =====================================================
    // pin roles, timers, gpio mirror
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_c_oe_b_out         <= 1'b1;
            pin_d_oe_b_out         <= 1'b1;
            slave_irq_out          <= 1'b0;
            timer_input_zero_out   <= 1'b0;
            timer_input_one_out    <= 1'b0;
            gpio_bit_thirtyone_out <= 1'b0;
            dma_chan_request_out   <= 2'h0;
        end else begin
            pin_c_oe_b_out <= ~cfg_in.cascade_a;
            pin_d_oe_b_out <= ~(cfg_in.cascade_b | cfg_in.slave_mode);
            slave_irq_out  <= cfg_in.slave_mode & slave_irq_in;
            // timer pins ignored while demodulating
            timer_input_zero_out <= cfg_in.pwd_enable ? pwd_s : s[8];
            timer_input_one_out  <= cfg_in.pwd_enable ? ~pwd_s : s[9];
            gpio_bit_thirtyone_out <= pwd_s;
            dma_chan_request_out <= {s[6] & ~cfg_in.dma1_unused,
                                     s[5] & ~cfg_in.dma0_unused};
        end
    end

    // =====================================================
    // checks
    AST_TAKE_CLEARS_GIE: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        do_take |=> !gie_q) else $error("enable not cleared on take");
    AST_DMA0_TYPE: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (do_take && !cas_sel && win == 3'(IRP_SRC_DMA0)) |=> take_out.vector_type == IRP_TYPE_DMA0)
        else $error("dma0 type wrong");
    AST_DMA1_TYPE: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (do_take && !cas_sel && win == 3'(IRP_SRC_DMA1)) |=> take_out.vector_type == IRP_TYPE_DMA1)
        else $error("dma1 type wrong");
    AST_ACK_A: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (do_take && cas_sel && win == 3'(IRP_SRC_A)) |=> !cascade_ack_a_out [*2])
        else $error("ack a not two cycles");
    AST_ACK_B: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (do_take && cas_sel && win == 3'(IRP_SRC_B)) |=> !cascade_ack_b_out ##2 cascade_ack_b_out)
        else $error("ack b shape wrong");
    AST_MASK_BLOCKS: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        do_take |-> !cfg_in.mask[win]) else $error("masked source taken");
    AST_GPIO_MIRROR: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        gpio_bit_thirtyone_out == $past(pwd_s)) else $error("gpio bit 31 stale");
    AST_PWD_TIMERS: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        $past(cfg_in.pwd_enable) |-> timer_input_one_out == !timer_input_zero_out)
        else $error("timer inputs not complementary");
    AST_SYNC_DELAY: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        s[0] == $past(ext_request_a_in, 2)) else $error("sync depth wrong");
    COV_DIRECT: cover property (@(posedge clk_sys_in) do_take && !cas_sel);
    COV_CASCADE: cover property (@(posedge clk_sys_in) do_take && cas_sel);
    COV_SLAVE: cover property (@(posedge clk_sys_in) cfg_in.slave_mode && take_out.take);
    COV_PWD: cover property (@(posedge clk_sys_in) cfg_in.pwd_enable && do_take);
endmodule // irp_top

// >>> verilog/irp_pkg.sv
// package for the interrupt request pin logic: modes, vectors, carriers
// assumes a single 50 MHz processor clock domain
package irp_pkg;
    // =====================================================
    // source indices and vector type codes
    localparam int          IRP_NUM_SRC      = 7;
    localparam int          IRP_SRC_A        = 0;
    localparam int          IRP_SRC_B        = 1;
    localparam int          IRP_SRC_C        = 2;
    localparam int          IRP_SRC_D        = 3;
    localparam int          IRP_SRC_E        = 4;
    localparam int          IRP_SRC_DMA0     = 5;
    localparam int          IRP_SRC_DMA1     = 6;
    localparam logic [7:0]  IRP_TYPE_DMA0    = 8'h0A;
    localparam logic [7:0]  IRP_TYPE_DMA1    = 8'h0B;
    localparam logic [7:0]  IRP_TYPE_A       = 8'h0C;  // default base, parameterisable
    localparam int          IRP_GPIO_PWD_BIT = 31;
    localparam int          IRP_SYNC_STAGES  = 2;
    localparam logic [6:0]  IRP_RST_PEND     = 7'h00;

    // =====================================================
    // configuration carrier from the control unit
    typedef struct packed {
        logic       cascade_a;    // request a in cascade mode
        logic       cascade_b;    // request b in cascade mode
        logic       slave_mode;   // unit slaved to external master
        logic       pwd_enable;   // pulse width demodulation on
        logic       dma0_unused;  // dma0 pin used as request
        logic       dma1_unused;  // dma1 pin used as request
        logic [6:0] level_mode;   // 1 = level, 0 = edge per source
        logic [6:0] mask;         // 1 = masked
    } irp_cfg_type;

    // vectoring carrier toward the processor core
    typedef struct packed {
        logic       take;         // interrupt taken this cycle
        logic [7:0] vector_type;  // vector table entry
        logic [2:0] source;       // winning source index
    } irp_take_type;

    typedef enum logic [1:0] {
        IRP_ST_IDLE = 2'b00,
        IRP_ST_ACK  = 2'b01,
        IRP_ST_WAIT = 2'b11
    } irp_state_type;
endpackage

// >>> verilog/irp_sync.sv
// two-stage synchroniser bank for asynchronous request pins
// assumes inputs come straight from pins, clocked by clk_sys_in
`timescale 1ns/1ns
module irp_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_sys_in,
    input  wire logic             rst_b_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    import irp_pkg::*;
    logic [WIDTH-1:0] meta_q;

    // =====================================================
    // first stage read only by the second stage
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // irp_sync

// >>> tb/irp_src_model.sv
// far-side model: external request sources and a slaving master controller
// assumes the bench drives raise_in and sel_go_in shortly after the clock edge
`timescale 1ns/1ns
module irp_src_model (
    input  wire logic                  clk_sys_in,
    input  wire logic                  rst_b_in,
    input  wire logic [6:0]            raise_in,
    input  wire logic                  sel_go_in,
    input  wire irp_pkg::irp_take_type take_in,
    output logic      [6:0]            req_out,
    output logic                       select_b_out
);
    import irp_pkg::*;
    // =====================================================
    // held requests
    logic [1:0] sel_cnt_q;
    logic       sel_used_q;
    logic [6:0] clr;
    // a taken select-vectored request clears request a, else the named source
    assign clr = take_in.take ? (7'h01 << (sel_used_q ? 3'h0 : take_in.source)) : 7'h00;
    // level-mode sources are not latched inside the dut, so hold until the take names this source
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            req_out <= 7'h00;
        end else begin
            req_out <= (req_out & ~clr) | raise_in;
        end
    end
    // =====================================================
    // select strobe, only ever after request a is up
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sel_cnt_q  <= 2'h0;
            sel_used_q <= 1'b0;
        end else begin
            if (sel_go_in && req_out[0]) begin
                sel_cnt_q  <= 2'h2;
                sel_used_q <= 1'b1;
            end else begin
                if (sel_cnt_q != 2'h0) sel_cnt_q <= sel_cnt_q - 2'h1;
                if (take_in.take) sel_used_q <= 1'b0;
            end
        end
    end
    assign select_b_out = (sel_cnt_q == 2'h0);
endmodule // irp_src_model

// >>> tb/irp_top_bench.sv
// self-checking bench for the interrupt request pin logic
// assumes the core is always at an instruction boundary
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin \
    $display("mismatch %s exp %0h got %0h", nm, ex, gt); n_mismatch++; end end
module irp_top_bench;
    import irp_pkg::*;
    typedef struct packed { logic [2:0] src; logic [7:0] vec; } irp_row_type;
    logic clk_sys_in = 1'b0, rst_b_in = 1'b0, sti_in = 1'b0, sel_go = 1'b0;
    logic pwd_in = 1'b0, slave_irq_in = 1'b0, tpin = 1'b0, pin_b_sel = 1'b0;
    logic [7:0] bus_type_in = 8'h00;
    logic [6:0] raise = 7'h00, req;
    logic sel_b;
    irp_cfg_type cfg = '0;
    irp_take_type take_out;
    logic global_enable_out, cascade_ack_a_out, cascade_ack_b_out, pin_d_oe_b_out;
    logic pin_c_oe_b_out, slave_irq_out, t0_out, t1_out, gpio_out;
    logic [1:0] dma_out;
    int n_mismatch = 0, samples_checked = 0, cycles = 0;
    irp_row_type rows [7] = '{'{3'h0, IRP_TYPE_A}, '{3'h1, IRP_TYPE_A + 8'h01},
        '{3'h2, IRP_TYPE_A + 8'h02}, '{3'h3, IRP_TYPE_A + 8'h03},
        '{3'h4, IRP_TYPE_A + 8'h04}, '{3'h5, IRP_TYPE_DMA0}, '{3'h6, IRP_TYPE_DMA1}};
    // =====================================================
    // clock, timeout, instances
    always #10 clk_sys_in = ~clk_sys_in;
    // runaway guard well above the few hundred cycles the run needs
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            results();
        end
    end
    irp_src_model src_u (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .raise_in(raise),
        .sel_go_in(sel_go), .take_in(take_out), .req_out(req), .select_b_out(sel_b));
    irp_top dut_u (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .cfg_in(cfg),
        .ext_request_a_in(req[0]), .ext_request_b_in(pin_b_sel ? sel_b : req[1]),
        .ext_request_c_in(req[2]), .ext_request_d_in(req[3]), .ext_request_e_in(req[4]),
        .dma_chan0_request_in(req[5]), .dma_chan1_request_in(req[6]), .pwd_in(pwd_in),
        .timer_pin_zero_in(tpin), .timer_pin_one_in(tpin), .core_ready_in(1'b1),
        .sti_in(sti_in), .slave_irq_in(slave_irq_in), .bus_type_in(bus_type_in),
        .take_out(take_out), .global_enable_out(global_enable_out),
        .cascade_ack_a_out(cascade_ack_a_out), .cascade_ack_b_out(cascade_ack_b_out),
        .pin_d_oe_b_out(pin_d_oe_b_out), .pin_c_oe_b_out(pin_c_oe_b_out),
        .slave_irq_out(slave_irq_out), .timer_input_zero_out(t0_out),
        .timer_input_one_out(t1_out), .gpio_bit_thirtyone_out(gpio_out),
        .dma_chan_request_out(dma_out));
    // =====================================================
    // shared tasks
    task automatic tick();
        @(posedge clk_sys_in);
        #2;
    endtask
    task automatic pulse_sti();
        sti_in = 1'b1;
        tick();
        sti_in = 1'b0;
    endtask
    task automatic raise_src(input int idx);
        raise = 7'h01 << idx;
        tick();
        raise = 7'h00;
    endtask
    // fixed window: counts takes and ack-low cycles, grabs what the take carried
    task automatic wait_take(input int exp_t, input logic [2:0] src, input logic [7:0] vec,
                             input int ack_exp, input bit do_sti);
        int n_t;
        int n_a;
        irp_take_type got;
        n_t = 0;
        n_a = 0;
        got = '0;
        repeat (12) begin
            tick();
            if (take_out.take === 1'b1) begin
                n_t++;
                got = take_out;
            end
            if (cascade_ack_a_out === 1'b0 || cascade_ack_b_out === 1'b0) n_a++;
        end
        `CHK("takes", exp_t, n_t)
        `CHK("ack_cycles", ack_exp, n_a)
        if (exp_t == 1) begin
            `CHK("vector", vec, got.vector_type)
            if (src != 3'h7) `CHK("source", src, got.source)
            `CHK("global_enable", 1'b0, global_enable_out)
        end
        if (do_sti) pulse_sti();
    endtask
    task automatic results();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // =====================================================
    // main sequence
    initial begin
        cfg.dma0_unused = 1'b1;
        cfg.dma1_unused = 1'b1;
        repeat (2) tick();
        `CHK("reset_oe", 2'h3, {pin_c_oe_b_out, pin_d_oe_b_out})
        rst_b_in = 1'b1;
        tick();
        pulse_sti();
        // every source plain, lowest to highest
        for (int i = 0; i < 7; i++) begin
            raise_src(rows[i].src);
            wait_take(1, rows[i].src, rows[i].vec, 0, 1'b1);
        end
        // masked, then released: the edge stays pending
        cfg.mask = 7'h01;
        raise_src(0);
        wait_take(0, 3'h0, 8'h00, 0, 1'b0);
        cfg.mask = 7'h00;
        wait_take(1, 3'h0, IRP_TYPE_A, 0, 1'b0);
        // global enable low after a take refuses the next request until sti
        raise_src(1);
        wait_take(0, 3'h1, 8'h00, 0, 1'b1);
        wait_take(1, 3'h1, IRP_TYPE_A + 8'h01, 0, 1'b1);
        // cascade on a, then on b
        cfg.cascade_a = 1'b1;
        bus_type_in = 8'h5A;
        raise_src(0);
        wait_take(1, 3'h0, 8'h5A, 2, 1'b1);
        `CHK("pin_c_oe", 1'b0, pin_c_oe_b_out)
        cfg.cascade_a = 1'b0;
        cfg.cascade_b = 1'b1;
        bus_type_in = 8'hA5;
        raise_src(1);
        wait_take(1, 3'h1, 8'hA5, 2, 1'b1);
        `CHK("pin_d_oe", 1'b0, pin_d_oe_b_out)
        cfg.cascade_b = 1'b0;
        // slave: request forwarded out, type fetched on select
        cfg.slave_mode = 1'b1;
        pin_b_sel = 1'b1;
        slave_irq_in = 1'b1;
        bus_type_in = 8'h3C;
        raise_src(0);
        repeat (4) tick();
        `CHK("slave_irq", 1'b1, slave_irq_out)
        `CHK("pin_d_oe_slave", 1'b0, pin_d_oe_b_out)
        sel_go = 1'b1;
        tick();
        sel_go = 1'b0;
        wait_take(1, 3'h7, 8'h3C, 0, 1'b1);
        // pin b back to a request first, so its synced level is low before slave mode ends
        pin_b_sel = 1'b0;
        repeat (3) tick();
        cfg.slave_mode = 1'b0;
        slave_irq_in = 1'b0;
        // demodulator: high drives c and timer zero, falling drives e
        // settled high before enabling, else the inverse looks like a fresh edge on e
        pwd_in = 1'b1;
        tpin = 1'b1;
        repeat (3) tick();
        cfg.pwd_enable = 1'b1;
        wait_take(1, 3'h2, IRP_TYPE_A + 8'h02, 0, 1'b1);
        `CHK("timers_hi", 3'h5, {t0_out, t1_out, gpio_out})
        raise_src(4);
        wait_take(0, 3'h4, 8'h00, 0, 1'b0);
        pwd_in = 1'b0;
        wait_take(1, 3'h4, IRP_TYPE_A + 8'h04, 0, 1'b1);
        `CHK("timers_lo", 3'h2, {t0_out, t1_out, gpio_out})
        // timer pins followed again once demodulation is off
        cfg.pwd_enable = 1'b0;
        tick();
        `CHK("timers_pin", 2'h3, {t0_out, t1_out})
        // dma0 in use: pin passed to the channel, no request
        cfg.dma0_unused = 1'b0;
        raise_src(5);
        repeat (4) tick();
        `CHK("dma_out", 2'h1, dma_out)
        cfg.dma0_unused = 1'b1;
        wait_take(1, 3'h5, IRP_TYPE_DMA0, 0, 1'b1);
        // level-recognised source d
        cfg.level_mode = 7'h08;
        raise_src(3);
        wait_take(1, 3'h3, IRP_TYPE_A + 8'h03, 0, 1'b1);
        // second reset in mid-run
        rst_b_in = 1'b0;
        tick();
        `CHK("reset_gie", 1'b0, global_enable_out)
        `CHK("reset_ack", 2'h3, {cascade_ack_a_out, cascade_ack_b_out})
        // release again: a fresh request is served normally
        rst_b_in = 1'b1;
        tick();
        pulse_sti();
        raise_src(2);
        wait_take(1, 3'h2, IRP_TYPE_A + 8'h02, 0, 1'b0);
        results();
    end
endmodule // irp_top_bench
